// ### rtl/pdsn_consts.vh
`ifndef PDSN_CONSTS_VH
`define PDSN_CONSTS_VH

// Register indices on the host register port.
`define PDSN_ADDR_SRC_CAPS 8'h32
`define PDSN_ADDR_SINK_CAPS 8'h33
`define PDSN_ADDR_ACT_OBJ 8'h34
`define PDSN_ADDR_ACT_REQ 8'h35
`define PDSN_ADDR_NEG_CFG 8'h37

// Register widths in bits.
`define PDSN_SRC_W 504
`define PDSN_SINK_W 424
`define PDSN_CFG_W 192
`define PDSN_OBJ_W 48
`define PDSN_REQ_W 96
`define PDSN_WIDE_W 512

// Field mask helper over the widest register.
`define PDSN_FMASK(hi, lo) ((512'h1 << ((hi) + 1)) - (512'h1 << (lo)))

// Capability list fields.
`define PDSN_CNT_STD_LO 0
`define PDSN_CNT_EXT_LO 3
`define PDSN_CNT_STD_MAX 3'h7
`define PDSN_CNT_EXT_MAX 3'h6
`define PDSN_SRC_PATH_LO 8
`define PDSN_PATH_INT5V 2'h0
`define PDSN_PATH_EXT 2'h2
`define PDSN_SRC_MASK (`PDSN_FMASK(439, 24) | `PDSN_FMASK(9, 8) | `PDSN_FMASK(5, 0))
`define PDSN_SINK_MASK (`PDSN_FMASK(423, 8) | `PDSN_FMASK(5, 0))
`define PDSN_SRC_RESET ((512'h2C << 56) | (512'h2601912C << 24) | 512'h1)
`define PDSN_SINK_RESET ((512'h0002D12C << 40) | (512'h3601912C << 8) | 512'h4)

// Negotiation configuration fields.
`define PDSN_AVS_V_LO 169
`define PDSN_AVS_I_LO 160
`define PDSN_AVS_EN 128
`define PDSN_PPS_V_LO 105
`define PDSN_PPS_I_LO 96
`define PDSN_PPS_NONAPDO_OFF 69
`define PDSN_PPS_FULL_RANGE 68
`define PDSN_PPS_CV_MODE 67
`define PDSN_PPS_IVL_LO 65
`define PDSN_PPS_EN 64
`define PDSN_MISM_PWR_LO 52
`define PDSN_MIN_V_LO 42
`define PDSN_MAX_V_LO 32
`define PDSN_MIN_PWR_LO 22
`define PDSN_MAX_I_LO 12
`define PDSN_AUTO_MAX_V 5
`define PDSN_AUTO_MIN_V 4
`define PDSN_MISM_DIS 3
`define PDSN_NO_USB_SUSP 1
`define PDSN_PRIO_LOW_V 0
`define PDSN_CFG_MASK (`PDSN_FMASK(180, 169) | `PDSN_FMASK(166, 160) | `PDSN_FMASK(128, 128) | \
  `PDSN_FMASK(115, 105) | `PDSN_FMASK(102, 96) | `PDSN_FMASK(69, 64) | `PDSN_FMASK(61, 12) | `PDSN_FMASK(6, 0))
`define PDSN_CFG_RESET ((512'h64 << 42) | (512'h190 << 32) | (512'h104 << 22) | (512'h145 << 12) | 512'h3E)

// Power conversion: 250 mW steps against 50 mV x 10 mA = 0.5 mW products.
`define PDSN_PWR_SCALE 19'h001F4

// Periodic programmable-supply request timing: one second at 100 MHz.
`define PDSN_PPS_BASE_CYCLES 30'h05F5E100

`endif

// ### rtl/pdsn_pps_timer.v
`timescale 1ns/100ps
`include "pdsn_consts.vh"

module pdsn_pps_timer #(
  parameter [29:0] BASE_CYCLES = `PDSN_PPS_BASE_CYCLES
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire run_i,
  input wire restart_i,
  input wire [1:0] interval_i,
  output reg expire_o
);

  reg [29:0] tick_cnt;
  reg [3:0] sec_cnt;
  reg [3:0] sec_goal;

  // Code 0 waits 8 base periods, each step up halves it.
  always @* begin
    case (interval_i)
      2'h0: sec_goal = 4'h8;
      2'h1: sec_goal = 4'h4;
      2'h2: sec_goal = 4'h2;
      default: sec_goal = 4'h1;
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt <= 30'h00000000;
      sec_cnt <= 4'h0;
      expire_o <= 1'b0;
    end else if (ce_i) begin
      expire_o <= 1'b0;
      if (!run_i || restart_i) begin
        tick_cnt <= 30'h00000000;
        sec_cnt <= 4'h0;
      end else if (tick_cnt == BASE_CYCLES - 30'h00000001) begin
        tick_cnt <= 30'h00000000;
        if (sec_cnt + 4'h1 >= sec_goal) begin
          sec_cnt <= 4'h0;
          expire_o <= 1'b1;
        end else begin
          sec_cnt <= sec_cnt + 4'h1;
        end
      end else begin
        tick_cnt <= tick_cnt + 30'h00000001;
      end
    end
  end

endmodule

// ### rtl/pdsn_regs.v
// Functional notes
// - Cap counts: standard max 7, extended max 6
// - First source object path: 0 internal, 2 external
// - Answer sink cap query with sink list
// - Sink list sampled only when transmitting
// - Contract object holds accepted object, else zero
// - Control field mirrors first object bits 29:20
// - Request register holds contract request fields
// - AVS enable seeks adjustable-voltage contract (only while PPS enable is clear; with pps_en set AVS objects are skipped)
// - PPS voltage copied unchanged into request
// - PPS current copied unchanged into request
// - Non-programmable choice disables sink path in the same cycle as its request
// - Full-range bit rejects narrow programmable sources
// - Mode bit picks disconnect threshold level
// - PPS requests resent at coded interval
// - PPS enable prefers programmable supply contracts
// - Low offered power sets mismatch flag
// - Host minimum voltage bounds selection when manual
// - Host maximum voltage bounds selection when manual
// - Seek at least the minimum sink power
// - Never request above maximum current field (fixed requests only; PPS and AVS currents are copied unclamped)
// - Mismatch disable bit suppresses mismatch flag
// - Auto bit selects zero minimum voltage
`timescale 1ns/100ps
`include "pdsn_consts.vh"

module pdsn_regs #(
  parameter [29:0] PPS_BASE_CYCLES = `PDSN_PPS_BASE_CYCLES
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire [7:0] host_addr_i,
  input wire [5:0] host_byte_i,
  input wire host_wr_i,
  input wire [7:0] host_wdata_i,
  input wire host_rd_i,
  output reg [7:0] host_rdata_o,
  output reg host_rvalid_o,
  input wire get_sink_cap_i,
  input wire sink_cap_override_i,
  output reg sink_caps_tx_valid_o,
  output reg [423:0] sink_caps_tx_o,
  input wire src_pdo_valid_i,
  input wire [31:0] src_pdo_i,
  input wire src_pdo_last_i,
  output reg request_valid_o,
  output reg [31:0] request_rdo_o,
  input wire contract_accept_i,
  input wire contract_clear_i,
  output reg sink_path_disable_o,
  output wire internal_5v_power_path_o,
  output wire external_power_path_o,
  output wire cv_mode_o,
  output wire disconnect_thresh_low_o
);

  localparam [2:0] S_IDLE = 3'b001;
  localparam [2:0] S_EVAL = 3'b010;
  localparam [2:0] S_SEND = 3'b100;

  reg [`PDSN_SRC_W-1:0] outgoing_source_caps;
  reg [`PDSN_SINK_W-1:0] outgoing_sink_caps;
  reg [`PDSN_CFG_W-1:0] sink_negotiation_config;
  reg [31:0] act_pdo;
  reg [9:0] act_ctrl;
  reg [31:0] act_rdo;
  reg [2:0] state;
  reg [3:0] obj_pos;
  reg [9:0] first_ctrl;
  reg [31:0] first_pdo;
  reg fix_found;
  reg [3:0] fix_pos;
  reg [19:0] fix_pwr;
  reg [9:0] fix_v;
  reg [9:0] fix_i;
  reg prog_found;
  reg prog_is_avs;
  reg [3:0] prog_pos;
  reg [31:0] fix_pdo;
  reg [31:0] prog_pdo;
  reg [31:0] pend_pdo;
  reg [31:0] pend_rdo;
  reg pend_is_prog;
  reg [`PDSN_WIDE_W-1:0] next_src;
  reg [`PDSN_WIDE_W-1:0] next_sink;
  reg [`PDSN_WIDE_W-1:0] next_cfg;
  reg [`PDSN_WIDE_W-1:0] rd_vec;
  wire pps_expire;

  wire [`PDSN_WIDE_W-1:0] src_mask = `PDSN_SRC_MASK;
  wire [`PDSN_WIDE_W-1:0] sink_mask = `PDSN_SINK_MASK;
  wire [`PDSN_WIDE_W-1:0] cfg_mask = `PDSN_CFG_MASK;
  // Reset images are constants so the asynchronous reset branch loads no logic.
  localparam [`PDSN_WIDE_W-1:0] src_rst = `PDSN_SRC_RESET;
  localparam [`PDSN_WIDE_W-1:0] sink_rst = `PDSN_SINK_RESET;
  localparam [`PDSN_WIDE_W-1:0] cfg_rst = `PDSN_CFG_RESET;

  function [2:0] pdsn_sat;
    input [2:0] val;
    input [2:0] lim;
    begin
      pdsn_sat = (val > lim) ? lim : val;
    end
  endfunction

  // Configuration fields.
  wire [11:0] avs_v = sink_negotiation_config[`PDSN_AVS_V_LO +: 12];
  wire [6:0] avs_i = sink_negotiation_config[`PDSN_AVS_I_LO +: 7];
  wire avs_en = sink_negotiation_config[`PDSN_AVS_EN];
  wire [10:0] pps_v = sink_negotiation_config[`PDSN_PPS_V_LO +: 11];
  wire [6:0] pps_i = sink_negotiation_config[`PDSN_PPS_I_LO +: 7];
  wire pps_off_nonapdo = sink_negotiation_config[`PDSN_PPS_NONAPDO_OFF];
  wire pps_full = sink_negotiation_config[`PDSN_PPS_FULL_RANGE];
  wire [1:0] pps_ivl = sink_negotiation_config[`PDSN_PPS_IVL_LO +: 2];
  wire pps_en = sink_negotiation_config[`PDSN_PPS_EN];
  wire [9:0] mism_pwr = sink_negotiation_config[`PDSN_MISM_PWR_LO +: 10];
  wire [9:0] cfg_min_v = sink_negotiation_config[`PDSN_MIN_V_LO +: 10];
  wire [9:0] cfg_max_v = sink_negotiation_config[`PDSN_MAX_V_LO +: 10];
  wire [9:0] min_pwr = sink_negotiation_config[`PDSN_MIN_PWR_LO +: 10];
  wire [9:0] max_i = sink_negotiation_config[`PDSN_MAX_I_LO +: 10];
  wire auto_max_v = sink_negotiation_config[`PDSN_AUTO_MAX_V];
  wire auto_min_voltage_sel = sink_negotiation_config[`PDSN_AUTO_MIN_V];
  wire mismatch_report_disable = sink_negotiation_config[`PDSN_MISM_DIS];
  wire no_usb_susp = sink_negotiation_config[`PDSN_NO_USB_SUSP];
  wire prio_low_v = sink_negotiation_config[`PDSN_PRIO_LOW_V];

  // Automatic limits accept the whole range for fixed objects; the full-range PPS check uses cfg_min_v and cfg_max_v regardless.
  wire [9:0] negotiation_min_voltage = auto_min_voltage_sel ? 10'h000 : cfg_min_v;
  wire [9:0] win_max_v = auto_max_v ? 10'h3FF : cfg_max_v;

  wire [1:0] path_sel = outgoing_source_caps[`PDSN_SRC_PATH_LO +: 2];
  assign internal_5v_power_path_o = (path_sel == `PDSN_PATH_INT5V);
  assign external_power_path_o = (path_sel == `PDSN_PATH_EXT);
  assign cv_mode_o = sink_negotiation_config[`PDSN_PPS_CV_MODE];
  assign disconnect_thresh_low_o = ~sink_negotiation_config[`PDSN_PPS_CV_MODE];

  // Per-object evaluation of the streamed partner source list.
  wire [1:0] pdo_type = src_pdo_i[31:30];
  wire [1:0] apdo_sub = src_pdo_i[29:28];
  wire [9:0] fx_v = src_pdo_i[19:10];
  wire [9:0] fx_i = src_pdo_i[9:0];
  wire [19:0] fx_pwr = fx_v * fx_i;
  wire [8:0] ap_max_v2 = {src_pdo_i[24:17], 1'b0};
  wire [8:0] ap_min_v2 = {src_pdo_i[15:8], 1'b0};
  wire [10:0] ap_max_v5 = src_pdo_i[24:17] * 3'h5;
  wire [10:0] ap_min_v5 = src_pdo_i[15:8] * 3'h5;
  wire [9:0] ap_i5 = src_pdo_i[6:0] * 3'h5;
  wire fx_ok = (pdo_type == 2'h0) && (fx_v >= negotiation_min_voltage) && (fx_v <= win_max_v);
  wire fx_better = !fix_found || (fx_pwr > fix_pwr) ||
    ((fx_pwr == fix_pwr) && (prio_low_v ? (fx_v < fix_v) : (fx_v > fix_v)));
  wire pps_range_ok = pps_full ?
    (({1'b0, ap_min_v2} <= cfg_min_v) && ({1'b0, ap_max_v2} >= cfg_max_v) && (ap_i5 >= max_i)) :
    ((pps_v >= ap_min_v5) && (pps_v <= ap_max_v5));
  wire pps_ok = pps_en && (pdo_type == 2'h3) && (apdo_sub == 2'h0) && pps_range_ok;
  wire avs_ok = avs_en && !pps_en && (pdo_type == 2'h3) && (apdo_sub == 2'h1);

  // Request construction for the best fixed object and the chosen programmable object.
  wire [9:0] req_i = (fix_i > max_i) ? max_i : fix_i;
  wire [18:0] thr_mism = mism_pwr * `PDSN_PWR_SCALE;
  wire [18:0] thr_min = min_pwr * `PDSN_PWR_SCALE;
  wire low_pwr = !fix_found || (fix_pwr < {1'b0, thr_mism}) || (fix_pwr < {1'b0, thr_min});
  wire fix_mism = low_pwr && !mismatch_report_disable;
  wire [3:0] sel_pos = fix_found ? fix_pos : 4'h1;
  wire [31:0] fix_rdo = {sel_pos, 1'b0, fix_mism, 1'b0, no_usb_susp, 1'b0, 3'h0, req_i, req_i};
  wire [31:0] pps_rdo = {prog_pos, 2'h0, 1'b0, no_usb_susp, 1'b0, 3'h0, pps_v, 2'h0, pps_i};
  wire [31:0] avs_rdo = {prog_pos, 2'h0, 1'b0, no_usb_susp, 1'b0, 2'h0, avs_v, 2'h0, avs_i};

  // Host writes: merge one byte, drop reserved bits, saturate the object counts.
  always @* begin
    next_src = {8'h00, outgoing_source_caps};
    next_sink = {88'h0, outgoing_sink_caps};
    next_cfg = {320'h0, sink_negotiation_config};
    next_src[host_byte_i * 8 +: 8] = host_wdata_i;
    next_sink[host_byte_i * 8 +: 8] = host_wdata_i;
    next_cfg[host_byte_i * 8 +: 8] = host_wdata_i;
    next_src = next_src & src_mask;
    next_sink = next_sink & sink_mask;
    next_cfg = next_cfg & cfg_mask;
    next_src[2:0] = pdsn_sat(next_src[2:0], `PDSN_CNT_STD_MAX);
    next_src[5:3] = pdsn_sat(next_src[5:3], `PDSN_CNT_EXT_MAX);
    next_sink[2:0] = pdsn_sat(next_sink[2:0], `PDSN_CNT_STD_MAX);
    next_sink[5:3] = pdsn_sat(next_sink[5:3], `PDSN_CNT_EXT_MAX);
  end

  always @* begin
    case (host_addr_i)
      `PDSN_ADDR_SRC_CAPS: rd_vec = {8'h00, outgoing_source_caps};
      `PDSN_ADDR_SINK_CAPS: rd_vec = {88'h0, outgoing_sink_caps};
      `PDSN_ADDR_ACT_OBJ: rd_vec = {464'h0, 6'h00, act_ctrl, act_pdo};
      `PDSN_ADDR_ACT_REQ: rd_vec = {416'h0, 64'h0, act_rdo};
      `PDSN_ADDR_NEG_CFG: rd_vec = {320'h0, sink_negotiation_config};
      default: rd_vec = {`PDSN_WIDE_W{1'b0}};
    endcase
  end

  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      outgoing_source_caps <= src_rst[`PDSN_SRC_W-1:0];
      outgoing_sink_caps <= sink_rst[`PDSN_SINK_W-1:0];
      sink_negotiation_config <= cfg_rst[`PDSN_CFG_W-1:0];
      host_rdata_o <= 8'h00;
      host_rvalid_o <= 1'b0;
    end else if (ce_i) begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i) begin
        host_rdata_o <= rd_vec[host_byte_i * 8 +: 8];
      end
      if (host_wr_i) begin
        case (host_addr_i)
          `PDSN_ADDR_SRC_CAPS: outgoing_source_caps <= next_src[`PDSN_SRC_W-1:0];
          `PDSN_ADDR_SINK_CAPS: outgoing_sink_caps <= next_sink[`PDSN_SINK_W-1:0];
          `PDSN_ADDR_NEG_CFG: sink_negotiation_config <= next_cfg[`PDSN_CFG_W-1:0];
          default: outgoing_source_caps <= outgoing_source_caps;
        endcase
      end
    end
  end

  // The sink list is copied only at the moment of a query, so a host write in flight never tears a message.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sink_caps_tx_valid_o <= 1'b0;
      sink_caps_tx_o <= 424'h0;
    end else if (ce_i) begin
      sink_caps_tx_valid_o <= get_sink_cap_i && !sink_cap_override_i;
      if (get_sink_cap_i && !sink_cap_override_i) begin
        sink_caps_tx_o <= outgoing_sink_caps;
      end
    end
  end

  // Selection engine over the partner source list.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      obj_pos <= 4'h0;
      first_ctrl <= 10'h000;
      first_pdo <= 32'h00000000;
      fix_found <= 1'b0;
      fix_pos <= 4'h0;
      fix_pwr <= 20'h00000;
      fix_v <= 10'h000;
      fix_i <= 10'h000;
      fix_pdo <= 32'h00000000;
      prog_found <= 1'b0;
      prog_is_avs <= 1'b0;
      prog_pos <= 4'h0;
      prog_pdo <= 32'h00000000;
      pend_pdo <= 32'h00000000;
      pend_rdo <= 32'h00000000;
      pend_is_prog <= 1'b0;
      request_valid_o <= 1'b0;
      request_rdo_o <= 32'h00000000;
      sink_path_disable_o <= 1'b0;
    end else if (ce_i) begin
      request_valid_o <= 1'b0;
      case (state)
        S_IDLE: begin
          fix_found <= 1'b0;
          prog_found <= 1'b0;
          obj_pos <= 4'h1;
          if (src_pdo_valid_i) begin
            state <= S_EVAL;
            obj_pos <= 4'h2;
            first_ctrl <= src_pdo_i[29:20];
            first_pdo <= src_pdo_i;
            if (fx_ok) begin
              fix_found <= 1'b1;
              fix_pos <= 4'h1;
              fix_pwr <= fx_pwr;
              fix_v <= fx_v;
              fix_i <= fx_i;
              fix_pdo <= src_pdo_i;
            end
            if (src_pdo_last_i) begin
              state <= S_SEND;
            end
          end else if (pps_expire && pend_is_prog) begin
            request_valid_o <= 1'b1;
            request_rdo_o <= prog_is_avs ? avs_rdo : pps_rdo;
          end
        end
        S_EVAL: begin
          if (src_pdo_valid_i) begin
            obj_pos <= obj_pos + 4'h1;
            if (fx_ok && fx_better) begin
              fix_found <= 1'b1;
              fix_pos <= obj_pos;
              fix_pwr <= fx_pwr;
              fix_v <= fx_v;
              fix_i <= fx_i;
              fix_pdo <= src_pdo_i;
            end
            if ((pps_ok || avs_ok) && !prog_found) begin
              prog_found <= 1'b1;
              prog_is_avs <= avs_ok;
              prog_pos <= obj_pos;
              prog_pdo <= src_pdo_i;
            end
            if (src_pdo_last_i) begin
              state <= S_SEND;
            end
          end
        end
        S_SEND: begin
          state <= S_IDLE;
          request_valid_o <= 1'b1;
          pend_is_prog <= prog_found;
          if (prog_found) begin
            request_rdo_o <= prog_is_avs ? avs_rdo : pps_rdo;
            pend_rdo <= prog_is_avs ? avs_rdo : pps_rdo;
            pend_pdo <= prog_pdo;
            sink_path_disable_o <= 1'b0;
          end else begin
            request_rdo_o <= fix_rdo;
            pend_rdo <= fix_rdo;
            pend_pdo <= fix_found ? fix_pdo : first_pdo;
            // The path is opened again by a later programmable request, or by a fixed one with pps_en or pps_off_nonapdo clear.
            sink_path_disable_o <= pps_en && pps_off_nonapdo;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Active contract record; zero whenever no explicit contract stands.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_pdo <= 32'h00000000;
      act_ctrl <= 10'h000;
      act_rdo <= 32'h00000000;
    end else if (ce_i) begin
      if (contract_clear_i) begin
        act_pdo <= 32'h00000000;
        act_ctrl <= 10'h000;
        act_rdo <= 32'h00000000;
      end else if (contract_accept_i) begin
        act_pdo <= pend_pdo;
        act_ctrl <= first_ctrl;
        act_rdo <= pend_rdo;
      end
    end
  end

  pdsn_pps_timer #(
    .BASE_CYCLES(PPS_BASE_CYCLES)
  ) u_pps_timer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .run_i(pps_en && pend_is_prog && (act_rdo != 32'h00000000)),
    .restart_i(request_valid_o),
    .interval_i(pps_ivl),
    .expire_o(pps_expire)
  );

endmodule

// ### verification/pdsn_regs_checker.sv
`timescale 1ns/100ps
module pdsn_regs_checker (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire ce_i,
  input wire host_rd_i,
  input wire host_rvalid_o,
  input wire get_sink_cap_i,
  input wire sink_cap_override_i,
  input wire sink_caps_tx_valid_o,
  input wire [423:0] sink_caps_tx_o,
  input wire src_pdo_valid_i,
  input wire src_pdo_last_i,
  input wire request_valid_o,
  input wire [31:0] request_rdo_o,
  input wire sink_path_disable_o,
  input wire internal_5v_power_path_o,
  input wire external_power_path_o,
  input wire cv_mode_o,
  input wire disconnect_thresh_low_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_list_end;
    src_pdo_valid_i && src_pdo_last_i && ce_i;
  endsequence
  sequence s_send;
    !request_valid_o ##1 request_valid_o;
  endsequence
  a_read_latency: assert property (host_rd_i && ce_i |=> host_rvalid_o) else $error("read answer late");
  a_read_quiet: assert property (host_rvalid_o && $past(ce_i) |-> $past(host_rd_i))
    else $error("stray read answer");
  a_sink_reply: assert property (get_sink_cap_i && ce_i && !sink_cap_override_i |=> sink_caps_tx_valid_o)
    else $error("sink list not sent");
  a_sink_override: assert property (get_sink_cap_i && sink_cap_override_i && ce_i |=> !sink_caps_tx_valid_o)
    else $error("sink list sent on override");
  a_sink_hold: assert property (!sink_caps_tx_valid_o |-> $stable(sink_caps_tx_o)) else $error("sink data moved");
  a_request_timing: assert property (s_list_end |=> s_send) else $error("request not two cycles after list");
  a_rdo_hold: assert property ($changed(request_rdo_o) |-> request_valid_o) else $error("request moved idle");
  a_path_hold: assert property ($changed(sink_path_disable_o) |-> request_valid_o)
    else $error("sink path moved without request");
  a_path_exclusive: assert property (!(internal_5v_power_path_o && external_power_path_o))
    else $error("both power paths");
  a_mode_pair: assert property (cv_mode_o == !disconnect_thresh_low_o) else $error("mode and threshold disagree");
endmodule

bind pdsn_regs pdsn_regs_checker u_chk (
  .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .host_rd_i(host_rd_i), .host_rvalid_o(host_rvalid_o),
  .get_sink_cap_i(get_sink_cap_i), .sink_cap_override_i(sink_cap_override_i),
  .sink_caps_tx_valid_o(sink_caps_tx_valid_o), .sink_caps_tx_o(sink_caps_tx_o), .src_pdo_valid_i(src_pdo_valid_i),
  .src_pdo_last_i(src_pdo_last_i), .request_valid_o(request_valid_o), .request_rdo_o(request_rdo_o),
  .sink_path_disable_o(sink_path_disable_o), .internal_5v_power_path_o(internal_5v_power_path_o),
  .external_power_path_o(external_power_path_o), .cv_mode_o(cv_mode_o),
  .disconnect_thresh_low_o(disconnect_thresh_low_o));

// ### verification/pdsn_partner_model.sv
`timescale 1ns/100ps
module pdsn_partner_model (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire start_i,
  input wire [2:0] cnt_i,
  input wire [127:0] list_i,
  input wire req_i,
  output reg valid_o,
  output reg [31:0] pdo_o,
  output reg last_o,
  output reg accept_o
);
  reg busy;
  reg [2:0] idx;
  // Idle object lines toggle so that a stale value is never mistaken for data.
  always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      idx <= 3'h0;
      valid_o <= 1'b0;
      pdo_o <= 32'h0;
      last_o <= 1'b0;
      accept_o <= 1'b0;
    end else begin
      accept_o <= req_i;
      if (start_i && !busy) begin
        busy <= 1'b1;
        idx <= 3'h1;
        valid_o <= 1'b1;
        pdo_o <= list_i[31:0];
        last_o <= (cnt_i == 3'h1);
      end else if (busy && !last_o) begin
        idx <= idx + 3'h1;
        valid_o <= 1'b1;
        pdo_o <= list_i[idx * 32 +: 32];
        last_o <= (idx + 3'h1 == cnt_i);
      end else begin
        busy <= 1'b0;
        valid_o <= 1'b0;
        last_o <= 1'b0;
        pdo_o <= ~pdo_o;
      end
    end
  end
endmodule

// ### verification/pd_capability_and_sink_negotiation_regs_tb.sv
`timescale 1ns/100ps
`include "pdsn_consts.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; $display("unexpected at %0t: %0h not %0h", $time, (a), (b)); end end
module pd_capability_and_sink_negotiation_regs_tb;
  reg clk_sys_i = 0, rst_n_i = 0, host_wr_i = 0, host_rd_i = 0, get_sink_cap_i = 0, sink_cap_override_i = 0;
  reg start = 0, contract_clear_i = 0, ce = 1;
  reg [7:0] host_addr_i = 0, host_wdata_i = 0;
  reg [5:0] host_byte_i = 0;
  reg [127:0] list = 0;
  reg [2:0] cnt = 0;
  reg [511:0] v, cfg, exp_v;
  reg [31:0] r;
  integer errors = 0, num_checks = 0, i, k, gap;
  wire [7:0] host_rdata_o;
  wire [423:0] sink_caps_tx_o;
  wire [31:0] request_rdo_o, src_pdo_i;
  wire host_rvalid_o, sink_caps_tx_valid_o, request_valid_o, sink_path_disable_o, int5v, ext, cv, thr;
  wire src_pdo_valid_i, src_pdo_last_i, contract_accept_i;
  pdsn_regs #(.PPS_BASE_CYCLES(30'd20)) u_pdsn_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .host_addr_i(host_addr_i), .host_byte_i(host_byte_i), .host_wr_i(host_wr_i), .host_wdata_i(host_wdata_i),
    .host_rd_i(host_rd_i), .host_rdata_o(host_rdata_o), .host_rvalid_o(host_rvalid_o),
    .get_sink_cap_i(get_sink_cap_i), .sink_cap_override_i(sink_cap_override_i),
    .sink_caps_tx_valid_o(sink_caps_tx_valid_o), .sink_caps_tx_o(sink_caps_tx_o), .src_pdo_valid_i(src_pdo_valid_i),
    .src_pdo_i(src_pdo_i), .src_pdo_last_i(src_pdo_last_i), .request_valid_o(request_valid_o),
    .request_rdo_o(request_rdo_o), .contract_accept_i(contract_accept_i), .contract_clear_i(contract_clear_i),
    .sink_path_disable_o(sink_path_disable_o), .internal_5v_power_path_o(int5v), .external_power_path_o(ext),
    .cv_mode_o(cv), .disconnect_thresh_low_o(thr));
  pdsn_partner_model u_pdsn_partner_model (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start), .cnt_i(cnt),
    .list_i(list), .req_i(request_valid_o), .valid_o(src_pdo_valid_i), .pdo_o(src_pdo_i), .last_o(src_pdo_last_i),
    .accept_o(contract_accept_i));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task give_verdict;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask

  task wr_reg(input [7:0] a, input integer nb, input [511:0] d);
    integer j;
    begin
      for (j = 0; j < nb; j++) begin
        @(posedge clk_sys_i) #1;
        host_wr_i = 1;
        host_addr_i = a;
        host_byte_i = j[5:0];
        host_wdata_i = d[8 * j +: 8];
      end
      @(posedge clk_sys_i) #1;
      host_wr_i = 0;
    end
  endtask

  task rd_reg(input [7:0] a, input integer nb);
    integer j;
    begin
      v = 0;
      for (j = 0; j < nb; j++) begin
        @(posedge clk_sys_i) #1;
        host_rd_i = 1;
        host_addr_i = a;
        host_byte_i = j[5:0];
        @(posedge clk_sys_i) #1;
        host_rd_i = 0;
        `CHK(host_rvalid_o, 1'b1)
        v[8 * j +: 8] = host_rdata_o;
      end
    end
  endtask

  task put_cfg;
    wr_reg(`PDSN_ADDR_NEG_CFG, 24, cfg);
  endtask

  // The partner accepts every request, so each list leaves an active contract.
  task neg(input [127:0] l, input [3:0] pos);
    integer j;
    begin
      list = l;
      cnt = 3'h2;
      @(posedge clk_sys_i) #1;
      start = 1;
      @(posedge clk_sys_i) #1;
      start = 0;
      for (j = 0; j < 30 && request_valid_o !== 1'b1; j++) @(posedge clk_sys_i) #1;
      `CHK(request_valid_o, 1'b1)
      r = request_rdo_o;
      `CHK(r[31:28], pos)
      repeat (4) @(posedge clk_sys_i);
    end
  endtask

  initial begin
    #200000;
    errors++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge clk_sys_i);
    #1 rst_n_i = 1;
    cfg = 0;
    cfg[51:32] = {10'h064, 10'h190};
    cfg[31:12] = {10'h104, 10'h145};
    cfg[5:1] = 5'h1F;
    rd_reg(`PDSN_ADDR_NEG_CFG, 24);
    `CHK(v, cfg)
    ce = 0;
    wr_reg(`PDSN_ADDR_NEG_CFG, 1, 8'h00);
    ce = 1;
    rd_reg(`PDSN_ADDR_NEG_CFG, 1);
    `CHK(v[7:0], 8'h3E)
    exp_v = 0;
    exp_v[87:24] = {32'h0000002C, 32'h2601912C};
    exp_v[2:0] = 3'h1;
    rd_reg(`PDSN_ADDR_SRC_CAPS, 63);
    `CHK(v, exp_v)
    `CHK({int5v, ext}, 2'b10)
    rd_reg(`PDSN_ADDR_ACT_OBJ, 6);
    `CHK(v, 512'h0)
    rd_reg(`PDSN_ADDR_ACT_REQ, 12);
    `CHK(v, 512'h0)
    wr_reg(`PDSN_ADDR_SRC_CAPS, 1, 8'hFF);
    rd_reg(`PDSN_ADDR_SRC_CAPS, 1);
    `CHK(v[7:0], 8'h37)
    wr_reg(`PDSN_ADDR_SRC_CAPS, 2, 16'h0237);
    `CHK({int5v, ext}, 2'b01)
    wr_reg(`PDSN_ADDR_ACT_OBJ, 1, 8'hFF);
    rd_reg(`PDSN_ADDR_ACT_OBJ, 1);
    `CHK(v[7:0], 8'h00)
    exp_v = 0;
    exp_v[71:8] = {32'h0002D12C, 32'h3601912C};
    exp_v[15:0] = 16'h0F04;
    wr_reg(`PDSN_ADDR_SINK_CAPS, 2, 16'h0F04);
    for (i = 0; i < 2; i++) begin
      @(posedge clk_sys_i) #1;
      get_sink_cap_i = 1;
      sink_cap_override_i = i[0];
      @(posedge clk_sys_i) #1;
      get_sink_cap_i = 0;
      sink_cap_override_i = 0;
      `CHK(sink_caps_tx_valid_o, ~i[0])
      `CHK(sink_caps_tx_o, exp_v[423:0])
      wr_reg(`PDSN_ADDR_SINK_CAPS, 1, 8'h03);
    end
    neg({32'h0002D12C, 32'h2601912C}, 4'd2);
    `CHK(r[26], 1'b0)
    rd_reg(`PDSN_ADDR_ACT_OBJ, 6);
    `CHK(v[47:0], {6'h00, 10'h260, 32'h0002D12C})
    rd_reg(`PDSN_ADDR_ACT_REQ, 12);
    `CHK(v[95:28], {64'h0, 4'd2})
    @(posedge clk_sys_i) #1;
    contract_clear_i = 1;
    @(posedge clk_sys_i) #1;
    contract_clear_i = 0;
    rd_reg(`PDSN_ADDR_ACT_OBJ, 6);
    `CHK(v, 512'h0)
    rd_reg(`PDSN_ADDR_ACT_REQ, 12);
    `CHK(v, 512'h0)
    cfg[3] = 0;
    cfg[61:52] = 10'd200;
    cfg[21:12] = 10'd100;
    put_cfg;
    neg({32'h0002D12C, 32'h2601912C}, 4'd2);
    `CHK(r[26], 1'b1)
    `CHK(r[19:10] <= 10'd100 && r[9:0] <= 10'd100, 1'b1)
    cfg[21:12] = 10'h145;
    cfg[5] = 0;
    cfg[41:32] = 10'd100;
    put_cfg;
    neg({32'h0002D12C, 32'h2601912C}, 4'd1);
    cfg[5] = 1;
    cfg[41:32] = 10'h190;
    put_cfg;
    neg({32'h0002D064, 32'h2601912C}, 4'd1);
    cfg[4] = 0;
    cfg[51:42] = 10'd180;
    put_cfg;
    neg({32'h0002D064, 32'h2601912C}, 4'd2);
    cfg[4] = 1;
    cfg[67] = 1;
    cfg[64] = 1;
    cfg[115:96] = {11'd250, 2'b00, 7'd40};
    put_cfg;
    `CHK({cv, thr}, 2'b10)
    neg({32'hC0DC213C, 32'h2601912C}, 4'd2);
    `CHK(r[19:9], 11'd250)
    `CHK(r[6:0], 7'd40)
    cfg[69:68] = 2'b11;
    put_cfg;
    neg({32'hC0DC213C, 32'h2601912C}, 4'd1);
    `CHK(sink_path_disable_o, 1'b1)
    cfg[68] = 0;
    put_cfg;
    neg({32'hC0DC213C, 32'h2601912C}, 4'd2);
    `CHK(sink_path_disable_o, 1'b0)
    for (k = 0; k < 4; k++) begin
      cfg[66:65] = k[1:0];
      put_cfg;
      for (i = 0; i < 400 && request_valid_o !== 1'b1; i++) @(posedge clk_sys_i) #1;
      @(posedge clk_sys_i) #1;
      for (gap = 1; gap < 400 && request_valid_o !== 1'b1; gap++) @(posedge clk_sys_i) #1;
      // A resend lands two cycles after its span: one edge restarts the count, one registers the expiry.
      `CHK(gap, (160 >> k) + 2)
    end
    cfg[69] = 0;
    cfg[64] = 0;
    cfg[128] = 1;
    cfg[180:160] = {12'h320, 2'b00, 7'h20};
    put_cfg;
    neg({32'hD3C0968C, 32'h2601912C}, 4'd2);
    `CHK({r[20:9], r[6:0]}, {12'h320, 7'h20})
    give_verdict;
  end
endmodule
